// ===== srmc_pkg.sv
// package of constants for the switch reset and mode control block
package srmc_pkg;
  // ****************************************
  // strap codes and field positions
  // ****************************************
  localparam logic [3:0] MODE_NORMAL      = 4'h0;
  localparam logic [3:0] MODE_EEPROM      = 4'h1;
  localparam logic [3:0] MODE_FO_P0       = 4'h8;
  localparam logic [3:0] MODE_FO_P2       = 4'h9;
  localparam logic [3:0] MODE_EE_FO_P0    = 4'hA;
  localparam logic [3:0] MODE_EE_FO_P2    = 4'hB;
  localparam logic [3:0] MODE_RESET_VAL   = 4'h0;
  localparam logic [3:0] PORT_UP_A        = 4'h0;
  localparam logic [3:0] PORT_UP_B        = 4'h2;
  // switch control register: halt bit position
  localparam int         SWCTL_HALT_BIT   = 0;
  localparam int         SWCTL_WIDTH      = 8;
  localparam logic [7:0] SWCTL_RESET_VAL  = 8'h00;
  // ****************************************
  // timing: length of the internal reset procedure
  // ****************************************
  localparam int         RST_PROC_NS      = 100;
  localparam int         CLK_PERIOD_NS    = 4;
  localparam int         RST_PROC_CYC     =
    (RST_PROC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int         CNT_W            = 8;
  // ****************************************
  // sequencer states
  // ****************************************
  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_PROC  = 2'b01,
    ST_HOLD  = 2'b10,
    ST_RUN   = 2'b11
  } srmc_state_t;
endpackage : srmc_pkg

// ===== srmc_sync3.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module srmc_sync3 #(
  parameter int W = 1                  // bits synchronised
) (
  input  wire logic         clk,       // core clock
  input  wire logic         rst_n,     // async reset, active low
  input  wire logic [W-1:0] din,       // raw pin level
  output logic      [W-1:0] dout       // filtered level
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] nxt_dout;
  // only take a change once the two late stages agree
  assign nxt_dout = (s2_ff == s3_ff) ? s3_ff : dout;
  // shift chain; first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      dout  <= '0;
    end
    else
    begin
      s1_ff <= din;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      dout  <= nxt_dout;
    end
  end
endmodule : srmc_sync3

// ===== srmc_top.sv
// reset sequencer and boot mode decode for the switch
`timescale 1ns/10ps
module srmc_top #(
  parameter int PROC_CYC = srmc_pkg::RST_PROC_CYC  // reset procedure length
) (
  input  wire logic       clk,                 // 250 MHz core clock
  input  wire logic       rst_n,               // power-on reset, low
  input  wire logic       fundamental_reset_n, // board reset pin, low
  input  wire logic       reset_hold_request,  // hold-in-reset pin
  input  wire logic [3:0] switch_mode_strap,   // mode strap pins
  input  wire logic       ctl_wr,              // mgmt write strobe
  input  wire logic [7:0] ctl_wdata,           // mgmt write data
  output logic      [7:0] switch_control_reg,  // control register
  output logic            core_reset_n,        // internal logic reset
  output logic            link_reset,          // link fundamental reset
  output logic            mgmt_bus_en,         // both mgmt buses active
  output logic            cfg_access_en,       // register access allowed
  output logic            held_in_reset,       // held state indicator
  output logic            switch_run,          // normal operation
  output logic [3:0]      mode_ff,             // captured strap
  output logic            eeprom_init,         // eeprom init selected
  output logic            failover_en,         // failover selected
  output logic [3:0]      upstream_port,       // chosen upstream port
  output logic            mode_reserved        // reserved code seen
);
  // ****************************************
  // pin synchronisation
  // ****************************************
  logic       perst_n_s;
  logic       hold_s;
  logic [3:0] mode_s;
  logic [5:0] sync_q;
  // one shared chain; output split on named wires, not a concatenation
  srmc_sync3 #(.W(6)) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .din   ({fundamental_reset_n, reset_hold_request, switch_mode_strap}),
    .dout  (sync_q)
  );
  assign perst_n_s = sync_q[5];
  assign hold_s    = sync_q[4];
  assign mode_s    = sync_q[3:0];

  // ****************************************
  // sequencer
  // ****************************************
  srmc_pkg::srmc_state_t state_ff;
  srmc_pkg::srmc_state_t nxt_state;
  logic [srmc_pkg::CNT_W-1:0] cnt_ff;
  logic [srmc_pkg::CNT_W-1:0] nxt_cnt;
  logic                       hold_ff;
  logic                       nxt_hold;
  logic [3:0]                 nxt_mode;
  logic [7:0]                 nxt_ctl;
  logic                       halt_bit;
  logic                       proc_done;

  assign halt_bit  = switch_control_reg[srmc_pkg::SWCTL_HALT_BIT];
  assign proc_done = (cnt_ff == PROC_CYC[srmc_pkg::CNT_W-1:0] - 8'h01);

  // next-state; reset pin overrides every state
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      srmc_pkg::ST_RESET:
        if (perst_n_s) nxt_state = srmc_pkg::ST_PROC;
      srmc_pkg::ST_PROC:
        if (proc_done)
          nxt_state = hold_ff ? srmc_pkg::ST_HOLD
                              : srmc_pkg::ST_RUN;
      srmc_pkg::ST_HOLD:
        if (!halt_bit) nxt_state = srmc_pkg::ST_RUN;
      srmc_pkg::ST_RUN:
        nxt_state = srmc_pkg::ST_RUN;
      default:
        nxt_state = srmc_pkg::ST_RESET;
    endcase
    if (!perst_n_s) nxt_state = srmc_pkg::ST_RESET;
  end

  // counter runs only through the reset procedure
  assign nxt_cnt = (state_ff == srmc_pkg::ST_PROC) ? cnt_ff + 8'h01 : '0;

  // hold request is latched while the reset pin is low
  assign nxt_hold = (state_ff == srmc_pkg::ST_RESET) ? hold_s : hold_ff;

  // strap taken once at release; later wiggles ignored
  assign nxt_mode = (state_ff == srmc_pkg::ST_RESET && perst_n_s)
                    ? mode_s : mode_ff;

  // halt bit set on entry to hold; cleared by mgmt write or in the reset state
  always_comb
  begin
    nxt_ctl = switch_control_reg;
    if (state_ff == srmc_pkg::ST_RESET)
      nxt_ctl = srmc_pkg::SWCTL_RESET_VAL;
    else if (ctl_wr)
      nxt_ctl = ctl_wdata;
    if (state_ff == srmc_pkg::ST_PROC && proc_done && hold_ff)
      nxt_ctl[srmc_pkg::SWCTL_HALT_BIT] = 1'b1;
  end

  // state registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff           <= srmc_pkg::ST_RESET;
      cnt_ff             <= '0;
      hold_ff            <= 1'b0;
      mode_ff            <= srmc_pkg::MODE_RESET_VAL;
      switch_control_reg <= srmc_pkg::SWCTL_RESET_VAL;
    end
    else
    begin
      state_ff           <= nxt_state;
      cnt_ff             <= nxt_cnt;
      hold_ff            <= nxt_hold;
      mode_ff            <= nxt_mode;
      switch_control_reg <= nxt_ctl;
    end
  end

  // ****************************************
  // status outputs
  // ****************************************
  // core logic and link stay in reset until normal operation
  assign core_reset_n  = (state_ff == srmc_pkg::ST_RUN);
  assign link_reset    = (state_ff != srmc_pkg::ST_RUN);
  assign held_in_reset = (state_ff == srmc_pkg::ST_HOLD);
  assign mgmt_bus_en   = (state_ff == srmc_pkg::ST_HOLD) ||
                         (state_ff == srmc_pkg::ST_RUN);
  assign cfg_access_en = mgmt_bus_en;
  assign switch_run    = (state_ff == srmc_pkg::ST_RUN);

  // ****************************************
  // mode decode
  // ****************************************
  // reserved codes fall back to plain normal mode, flagged
  always_comb
  begin
    eeprom_init   = 1'b0;
    failover_en   = 1'b0;
    upstream_port = srmc_pkg::PORT_UP_A;
    mode_reserved = 1'b0;
    case (mode_ff)
      srmc_pkg::MODE_NORMAL:   ;
      srmc_pkg::MODE_EEPROM:   eeprom_init = 1'b1;
      srmc_pkg::MODE_FO_P0:    failover_en = 1'b1;
      srmc_pkg::MODE_FO_P2:
      begin
        failover_en   = 1'b1;
        upstream_port = srmc_pkg::PORT_UP_B;
      end
      srmc_pkg::MODE_EE_FO_P0:
      begin
        eeprom_init = 1'b1;
        failover_en = 1'b1;
      end
      srmc_pkg::MODE_EE_FO_P2:
      begin
        eeprom_init   = 1'b1;
        failover_en   = 1'b1;
        upstream_port = srmc_pkg::PORT_UP_B;
      end
      default: mode_reserved = 1'b1;
    endcase
  end

  // ****************************************
  // checks
  // ****************************************
  // release to run: one sync edge, then the full procedure
  localparam int RUN_LAT_MAX = PROC_CYC + 1;

  sequence hold_entry_s;
    state_ff == srmc_pkg::ST_PROC && proc_done && hold_ff;
  endsequence

  perst_clears_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    !perst_n_s |=> state_ff == srmc_pkg::ST_RESET && !core_reset_n)
    else $error("reset pin did not force reset state");

  hold_entry_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    hold_entry_s and perst_n_s |=> held_in_reset && halt_bit && mgmt_bus_en)
    else $error("hold request did not hold device");

  hold_write_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    held_in_reset && ctl_wr && perst_n_s
      |=> switch_control_reg == $past(ctl_wdata))
    else $error("write lost while held");

  halt_exit_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    held_in_reset && halt_bit && !ctl_wr
      |=> held_in_reset || state_ff == srmc_pkg::ST_RESET)
    else $error("left hold without clearing halt");

  halt_clear_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    held_in_reset && !halt_bit && perst_n_s |=> switch_run)
    else $error("cleared halt did not release");

  mode_keep_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    state_ff != srmc_pkg::ST_RESET |=> $stable(mode_ff))
    else $error("captured mode changed");

  fo_port_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    mode_ff == srmc_pkg::MODE_FO_P2 |-> failover_en && !eeprom_init
      && upstream_port == srmc_pkg::PORT_UP_B)
    else $error("failover port 2 decode wrong");

  ee_fo_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    mode_ff == srmc_pkg::MODE_EE_FO_P0 |-> failover_en && eeprom_init
      && upstream_port == srmc_pkg::PORT_UP_A)
    else $error("eeprom failover decode wrong");

  eeprom_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    mode_ff == srmc_pkg::MODE_EEPROM |-> eeprom_init && !failover_en)
    else $error("eeprom mode decode wrong");

  run_time_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    $rose(perst_n_s) && !hold_s
      |-> ##[1:RUN_LAT_MAX] switch_run || !perst_n_s)
    else $error("reset procedure too long");
endmodule : srmc_top

// ===== srmc_board.sv
// board reset logic and management master model for the mode block
`timescale 1ns/10ps
module srmc_board (
  input  wire logic clk,                 // core clock
  output logic       fundamental_reset_n, // board reset pin
  output logic       reset_hold_request,  // hold request pin
  output logic [3:0] switch_mode_strap,   // mode strap pins
  output logic       ctl_wr,              // mgmt write strobe
  output logic [7:0] ctl_wdata            // mgmt write data
);
  // board powers up with the reset pin low
  initial
  begin
    fundamental_reset_n = 1'h0;
    reset_hold_request  = 1'h0;
    switch_mode_strap   = 4'h0;
    ctl_wr              = 1'h0;
    ctl_wdata           = 8'h00;
  end
  // pin low with strap and hold set up; callers pass legal codes only
  task automatic pin_low(input logic [3:0] mode, input logic hold);
    @(negedge clk);
    fundamental_reset_n = 1'h0;
    switch_mode_strap   = mode;
    reset_hold_request  = hold;
  endtask : pin_low
  // release after the straps settled; strap is never touched here
  task automatic pin_release;
    repeat (8) @(negedge clk);
    fundamental_reset_n = 1'h1;
  endtask : pin_release
  // one-cycle write; released data shows the inverse, not a stale value
  task automatic mgmt_write(input logic [7:0] data);
    @(negedge clk);
    ctl_wr    = 1'h1;
    ctl_wdata = data;
    @(negedge clk);
    ctl_wr    = 1'h0;
    ctl_wdata = ~data;
  endtask : mgmt_write
  // strap moved after release, only when a scenario asks for it
  task automatic strap_move(input logic [3:0] mode);
    @(negedge clk);
    switch_mode_strap = mode;
  endtask : strap_move
endmodule : srmc_board

// ===== switch_reset_mode_control_tb.sv
// self-checking bench for the reset sequencer and mode decode
`timescale 1ns/10ps
`define CHK(got, exp) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) \
    begin \
      n_fail++; \
      $display("[FAIL] %0t got %h exp %h", $time, got, exp); \
    end \
  end
module switch_reset_mode_control_tb;
  logic       clk;
  logic       rst_n;
  logic       fund_n;
  logic       hold;
  logic [3:0] strap;
  logic       wr;
  logic [7:0] wdata;
  logic [7:0] ctl_reg;
  logic       core_n;
  logic       link_rst;
  logic       bus_en;
  logic       acc_en;
  logic       held;
  logic       run;
  logic [3:0] mode;
  logic       ee;
  logic       fo;
  logic [3:0] up;
  logic       rsv;
  int         n_fail;
  int         num_checks;
  int         cyc;
  // short reset procedure keeps the run brief
  srmc_top #(.PROC_CYC(4)) srmc_top_inst (
    .clk(clk), .rst_n(rst_n), .fundamental_reset_n(fund_n),
    .reset_hold_request(hold), .switch_mode_strap(strap),
    .ctl_wr(wr), .ctl_wdata(wdata), .switch_control_reg(ctl_reg),
    .core_reset_n(core_n), .link_reset(link_rst), .mgmt_bus_en(bus_en),
    .cfg_access_en(acc_en), .held_in_reset(held), .switch_run(run),
    .mode_ff(mode), .eeprom_init(ee), .failover_en(fo),
    .upstream_port(up), .mode_reserved(rsv));
  srmc_board srmc_board_inst (
    .clk(clk), .fundamental_reset_n(fund_n),
    .reset_hold_request(hold), .switch_mode_strap(strap),
    .ctl_wr(wr), .ctl_wdata(wdata));
  // 250 MHz clock
  initial
  begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  // hang guard; the whole run needs well under a thousand cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      n_fail++;
      stop_test();
    end
  end
  task automatic stop_test;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : stop_test
  // bounded wait for the end of the reset procedure
  task automatic wait_done;
    int i;
    for (i = 0; i < 60 && run !== 1'h1 && held !== 1'h1; i++)
      @(negedge clk);
    `CHK(run | held, 1'h1);
  endtask : wait_done
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_modes;
    logic [3:0] codes [6];
    logic [3:0] c;
    int k;
    codes = '{4'h0, 4'h1, 4'h8, 4'h9, 4'hA, 4'hB};
    for (k = 0; k < 6; k++)
    begin
      c = codes[k];
      srmc_board_inst.pin_low(c, 1'h0);
      srmc_board_inst.pin_release();
      wait_done();
      `CHK(run, 1'h1);
      `CHK({core_n, link_rst}, 2'h2);
      `CHK(mode, c);
      `CHK(ee, c == 4'h1 || c == 4'hA || c == 4'hB);
      `CHK(fo, c[3]);
      `CHK(rsv, 1'h0);
      if (c[3])
        `CHK(up, c[0] ? srmc_pkg::PORT_UP_B : srmc_pkg::PORT_UP_A);
    end
    // strap moved in mid-session must not reach the captured mode
    srmc_board_inst.strap_move(4'h8);
    repeat (10) @(negedge clk);
    `CHK(mode, 4'hB);
    `CHK(fo, 1'h1);
  endtask : t_modes
  task automatic t_hold;
    srmc_board_inst.pin_low(4'h1, 1'h1);
    srmc_board_inst.pin_release();
    wait_done();
    `CHK({held, run}, 2'h2);
    `CHK({bus_en, acc_en}, 2'h3);
    `CHK(ctl_reg[0], 1'h1);
    // a write that keeps the halt bit must not release the hold
    srmc_board_inst.mgmt_write(8'h01);
    repeat (20) @(negedge clk);
    `CHK({held, run}, 2'h2);
    srmc_board_inst.mgmt_write(8'h00);
    repeat (3) @(negedge clk);
    `CHK({held, run}, 2'h1);
    `CHK(ctl_reg[0], 1'h0);
    `CHK(mode, 4'h1);
  endtask : t_hold
  task automatic t_pin_reset;
    srmc_board_inst.pin_low(4'h9, 1'h0);
    repeat (6) @(negedge clk);
    `CHK({core_n, link_rst, run}, 3'h2);
    // writes while in reset are refused
    srmc_board_inst.mgmt_write(8'hFF);
    `CHK(ctl_reg, 8'h00);
    srmc_board_inst.pin_release();
    wait_done();
    `CHK(up, srmc_pkg::PORT_UP_B);
  endtask : t_pin_reset
  // main sequence
  initial
  begin
    rst_n = 1'h0;
    repeat (12) @(negedge clk);
    `CHK({core_n, link_rst, ctl_reg}, 10'h100);
    rst_n = 1'h1;
    t_modes();
    t_hold();
    t_pin_reset();
    stop_test();
  end
endmodule : switch_reset_mode_control_tb
